// *** rtl/srs_pkg.sv ***
package srs_pkg;

  localparam int          ADDR_W        = 20;
  localparam int          NUM_PORTS     = 7;
  // Fast-oscillator cycles that the internal sequence lasts at least.
  localparam int          SEQ_MIN_CYC   = 128;
  localparam logic [7:0]  SEQ_LAST      = 8'(SEQ_MIN_CYC - 1);
  // Processor clocks the reset pin must stay low before it is taken.
  localparam logic [1:0]  QUAL_TICKS    = 2'h3;
  localparam logic [3:0]  WAIT_RST      = 4'h4;
  localparam logic [7:0]  PRIO_RST      = 8'hFF;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [1:0]  CS_SEL_RST    = 2'h0;
  localparam logic        OE_SEL_RST    = 1'b0;
  localparam logic [1:0]  WE_EN_RST     = 2'h0;
  localparam logic [2:0]  PORT_B        = 3'h1;
  localparam logic [2:0]  PORT_C        = 3'h2;
  localparam logic [7:0]  PB_OE_RST     = 8'hC0;
  localparam logic [7:0]  PC_OE_RST     = 8'h55;
  localparam logic [7:0]  PC_DAT_RST    = 8'h15;

  typedef enum logic [1:0] {
    SRS_RUN   = 2'h0,
    SRS_DEFER = 2'h1,
    SRS_SEQ   = 2'h3,
    SRS_HOLD  = 2'h2
  } srs_state_t;

  typedef enum logic [2:0] {
    SRS_SEL_SP   = 3'h0,
    SRS_SEL_PC   = 3'h1,
    SRS_SEL_IVB  = 3'h2,
    SRS_SEL_EVB  = 3'h3,
    SRS_SEL_PRIO = 3'h4,
    SRS_SEL_MEM  = 3'h5,
    SRS_SEL_CLK  = 3'h6
  } srs_sel_t;

  // Active-low memory and I/O strobes as they leave the device.
  typedef struct packed {
    logic       csN0;
    logic       csN2;
    logic       oeN0;
    logic       oeN1;
    logic       weN0;
    logic       weN1;
    logic       bufEnN;
    logic       ioRdN;
    logic       ioWrN;
    logic       fetchN;
  } srs_memctl_t;

  // Active-high cycle requests from the processor core.
  typedef struct packed {
    logic       memRd;
    logic       memWr;
    logic       ioRd;
    logic       ioWr;
    logic       fetch;
  } srs_corereq_t;

  typedef struct packed {
    logic [15:0] stackPtr;
    logic [15:0] progCounter;
    logic [7:0]  internalVectorBase;
    logic [7:0]  externalVectorBase;
    logic [7:0]  priorityStackReg;
  } srs_cpu_t;

  typedef struct packed {
    logic [3:0] waitStates;
    logic [1:0] csSel;
    logic       oeSel;
    logic [1:0] weEn;
  } srs_memcfg_t;

  typedef struct packed {
    logic       en;
    srs_sel_t   sel;
    logic [15:0] data;
  } srs_cfgwr_t;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] dat;
  } srs_port_t;

  typedef struct packed {
    logic       en;
    logic [2:0] idx;
    srs_port_t  val;
  } srs_portwr_t;

endpackage

// *** rtl/srs_reset_sequencer.sv ***
`timescale 1ns/100ps

// How it works
// - Reset initialises all state but the RTC.
// - Pending memory write postpones entering reset.
// - No write pending: reset takes effect immediately.
// - Sequence lasts at least 128 fast cycles.
// - Reset sets processor and peripheral clocks divide-by-eight.
// - Count runs on fast clock, not processor clock.
// - Battery RAM select floats, other strobes high.
// - Pin released: fetching and strobes resume.
// - Bank control defaults to four wait states.
// - Battery RAM select also floats in power-down.
// - Power switch output high in reset, power-down.
// - Default chip select 0, output enable 0; no writes.
// - Interrupt priority register set to all ones.
// - SP, PC and vector bases cleared to zero.
// - Address and other strobes stay driven during reset.
// - Ports B and C get fixed defaults; others float.
module srs_reset_sequencer (
  input  wire logic                             sys_clk,
  input  wire logic                             nrst,
  input  wire logic                             clkEn,
  input  wire logic                             extResetN,
  input  wire logic                             cpuTick,
  input  wire logic                             writeBusy,
  input  wire logic                             powerDown,
  input  wire logic [srs_pkg::ADDR_W-1:0]       coreAddr,
  input  wire srs_pkg::srs_corereq_t            coreReq,
  input  wire srs_pkg::srs_cfgwr_t              cfgWr,
  input  wire srs_pkg::srs_portwr_t             portWr,
  output logic                                  coreResetN,
  output logic [srs_pkg::ADDR_W-1:0]            addrOut,
  output srs_pkg::srs_memctl_t                  memCtl,
  output logic                                  battRamSelOut,
  output logic                                  battRamSelOe,
  output logic                                  powerSwitchCtrlOut,
  output logic                                  cpuClkDiv8,
  output logic                                  perClkDiv8,
  output srs_pkg::srs_cpu_t                     cpuState,
  output srs_pkg::srs_memcfg_t                  memCfg,
  output srs_pkg::srs_port_t [srs_pkg::NUM_PORTS-1:0] portPins
);

  function automatic srs_pkg::srs_port_t portDefault(input logic [2:0] idx);
    srs_pkg::srs_port_t p;
    p.oe  = srs_pkg::BYTE_ZERO;
    p.dat = srs_pkg::BYTE_ZERO;
    if (idx == srs_pkg::PORT_B) begin
      p.oe = srs_pkg::PB_OE_RST;
    end else if (idx == srs_pkg::PORT_C) begin
      p.oe  = srs_pkg::PC_OE_RST;
      p.dat = srs_pkg::PC_DAT_RST;
    end
    return p;
  endfunction
  logic                 extRstMeta_ff;
  logic                 extRstSync_ff;
  logic [1:0]           lowTicks_ff;
  logic                 reqQual;
  srs_pkg::srs_state_t  state_ff;
  srs_pkg::srs_state_t  nxt_state;
  logic [7:0]           seqCnt_ff;
  logic                 seqDone;
  logic                 inReset;
  logic                 coreResetN_ff;
  logic [srs_pkg::ADDR_W-1:0] addr_ff;
  srs_pkg::srs_memctl_t memCtl_ff;
  srs_pkg::srs_memctl_t nxt_memCtl;
  logic                 battSel_ff;
  logic                 battOe_ff;
  logic                 powerSw_ff;
  logic                 cpuDiv8_ff;
  logic                 perDiv8_ff;
  srs_pkg::srs_cpu_t    cpu_ff;
  srs_pkg::srs_memcfg_t memCfg_ff;
  logic                 cfgLive;

  // Pin synchroniser; only the second stage is looked at.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      extRstMeta_ff <= 1'b1;
      extRstSync_ff <= 1'b1;
    end else if (clkEn) begin
      extRstMeta_ff <= extResetN;
      extRstSync_ff <= extRstMeta_ff;
    end
  end

  // Low level must persist for three processor clocks to be taken.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lowTicks_ff <= 2'h0;
    end else if (clkEn) begin
      if (extRstSync_ff) begin
        lowTicks_ff <= 2'h0;
      end else if (cpuTick && lowTicks_ff != srs_pkg::QUAL_TICKS) begin
        lowTicks_ff <= lowTicks_ff + 2'h1;
      end
    end
  end

  assign reqQual = (lowTicks_ff == srs_pkg::QUAL_TICKS);
  assign seqDone = (seqCnt_ff == srs_pkg::SEQ_LAST);
  assign inReset = (state_ff == srs_pkg::SRS_SEQ) || (state_ff == srs_pkg::SRS_HOLD);
  assign cfgLive = cfgWr.en && !inReset;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      srs_pkg::SRS_RUN: begin
        if (reqQual) begin
          nxt_state = writeBusy ? srs_pkg::SRS_DEFER : srs_pkg::SRS_SEQ;
        end
      end
      srs_pkg::SRS_DEFER: begin
        // A write on a slow processor clock may outlast the count.
        if (seqDone) begin
          nxt_state = srs_pkg::SRS_HOLD;
        end else if (!writeBusy) begin
          nxt_state = srs_pkg::SRS_SEQ;
        end
      end
      srs_pkg::SRS_SEQ: begin
        if (seqDone) begin
          nxt_state = srs_pkg::SRS_HOLD;
        end
      end
      srs_pkg::SRS_HOLD: begin
        if (extRstSync_ff) begin
          nxt_state = srs_pkg::SRS_RUN;
        end
      end
      default: begin
        nxt_state = srs_pkg::SRS_SEQ;
      end
    endcase
  end

  // Power-on enters the sequence so the minimum length also applies.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= srs_pkg::SRS_SEQ;
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end

  // The length count runs on the fast clock from the request onward.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      seqCnt_ff <= 8'h00;
    end else if (clkEn) begin
      if (state_ff == srs_pkg::SRS_RUN) begin
        seqCnt_ff <= 8'h00;
      end else if (!seqDone) begin
        seqCnt_ff <= seqCnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      coreResetN_ff <= 1'b0;
    end else if (clkEn) begin
      coreResetN_ff <= (nxt_state == srs_pkg::SRS_RUN);
    end
  end

  // Address lines stay driven; last value held, zero on release.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      addr_ff <= '0;
    end else if (clkEn) begin
      if (state_ff == srs_pkg::SRS_HOLD && nxt_state == srs_pkg::SRS_RUN) begin
        addr_ff <= '0;
      end else if (!inReset) begin
        addr_ff <= coreAddr;
      end
    end
  end

  always_comb begin
    nxt_memCtl = '1;
    if (!inReset) begin
      nxt_memCtl.csN0   = !((coreReq.memRd || coreReq.memWr) && memCfg_ff.csSel == 2'h0);
      nxt_memCtl.csN2   = !((coreReq.memRd || coreReq.memWr) && memCfg_ff.csSel == 2'h2);
      nxt_memCtl.oeN0   = !(coreReq.memRd && !memCfg_ff.oeSel);
      nxt_memCtl.oeN1   = !(coreReq.memRd && memCfg_ff.oeSel);
      nxt_memCtl.weN0   = !(coreReq.memWr && memCfg_ff.weEn[0]);
      nxt_memCtl.weN1   = !(coreReq.memWr && memCfg_ff.weEn[1]);
      nxt_memCtl.bufEnN = !(coreReq.memRd || coreReq.memWr || coreReq.ioRd || coreReq.ioWr);
      nxt_memCtl.ioRdN  = !coreReq.ioRd;
      nxt_memCtl.ioWrN  = !coreReq.ioWr;
      nxt_memCtl.fetchN = !coreReq.fetch;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      memCtl_ff <= '1;
    end else if (clkEn) begin
      memCtl_ff <= nxt_memCtl;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      battSel_ff <= 1'b1;
      battOe_ff  <= 1'b0;
      powerSw_ff <= 1'b1;
    end else if (clkEn) begin
      battSel_ff <= !((coreReq.memRd || coreReq.memWr) && memCfg_ff.csSel == 2'h1);
      battOe_ff  <= !(inReset || powerDown);
      powerSw_ff <= inReset || powerDown;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpuDiv8_ff <= 1'b1;
      perDiv8_ff <= 1'b1;
    end else if (clkEn) begin
      if (inReset) begin
        cpuDiv8_ff <= 1'b1;
        perDiv8_ff <= 1'b1;
      end else if (cfgLive && cfgWr.sel == srs_pkg::SRS_SEL_CLK) begin
        cpuDiv8_ff <= cfgWr.data[0];
        perDiv8_ff <= cfgWr.data[1];
      end
    end
  end

  // Processor registers; the real-time counter lives elsewhere, untouched.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_ff <= '0;
      cpu_ff.priorityStackReg <= srs_pkg::PRIO_RST;
    end else if (clkEn) begin
      if (inReset) begin
        cpu_ff.stackPtr           <= srs_pkg::WORD_ZERO;
        cpu_ff.progCounter        <= srs_pkg::WORD_ZERO;
        cpu_ff.internalVectorBase <= srs_pkg::BYTE_ZERO;
        cpu_ff.externalVectorBase <= srs_pkg::BYTE_ZERO;
        cpu_ff.priorityStackReg   <= srs_pkg::PRIO_RST;
      end else if (cfgLive) begin
        case (cfgWr.sel)
          srs_pkg::SRS_SEL_SP:   cpu_ff.stackPtr           <= cfgWr.data;
          srs_pkg::SRS_SEL_PC:   cpu_ff.progCounter        <= cfgWr.data;
          srs_pkg::SRS_SEL_IVB:  cpu_ff.internalVectorBase <= cfgWr.data[7:0];
          srs_pkg::SRS_SEL_EVB:  cpu_ff.externalVectorBase <= cfgWr.data[7:0];
          srs_pkg::SRS_SEL_PRIO: cpu_ff.priorityStackReg   <= cfgWr.data[7:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      memCfg_ff <= {srs_pkg::WAIT_RST, srs_pkg::CS_SEL_RST, srs_pkg::OE_SEL_RST,
                    srs_pkg::WE_EN_RST};
    end else if (clkEn) begin
      if (inReset) begin
        memCfg_ff.waitStates <= srs_pkg::WAIT_RST;
        memCfg_ff.csSel      <= srs_pkg::CS_SEL_RST;
        memCfg_ff.oeSel      <= srs_pkg::OE_SEL_RST;
        memCfg_ff.weEn       <= srs_pkg::WE_EN_RST;
      end else if (cfgLive && cfgWr.sel == srs_pkg::SRS_SEL_MEM) begin
        memCfg_ff <= cfgWr.data[8:0];
      end
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < srs_pkg::NUM_PORTS; gi++) begin : g_port
      srs_pkg::srs_port_t port_ff;
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          port_ff <= portDefault(3'(gi));
        end else if (clkEn) begin
          if (inReset) begin
            port_ff <= portDefault(3'(gi));
          end else if (portWr.en && portWr.idx == 3'(gi)) begin
            port_ff <= portWr.val;
          end
        end
      end
      assign portPins[gi] = port_ff;
    end
  endgenerate

  assign coreResetN         = coreResetN_ff;
  assign addrOut            = addr_ff;
  assign memCtl             = memCtl_ff;
  assign battRamSelOut      = battSel_ff;
  assign battRamSelOe       = battOe_ff;
  assign powerSwitchCtrlOut = powerSw_ff;
  assign cpuClkDiv8         = cpuDiv8_ff;
  assign perClkDiv8         = perDiv8_ff;
  assign cpuState           = cpu_ff;
  assign memCfg             = memCfg_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_reset_entered;
    clkEn && state_ff == srs_pkg::SRS_SEQ ##1 state_ff == srs_pkg::SRS_HOLD;
  endsequence
  sequence s_release;
    clkEn && state_ff == srs_pkg::SRS_HOLD && extRstSync_ff;
  endsequence
  property p_defer_write;
    clkEn && state_ff == srs_pkg::SRS_DEFER && writeBusy && !seqDone
      |=> state_ff == srs_pkg::SRS_DEFER;
  endproperty
  a_defer_write: assert property (p_defer_write) else $error("reset entered during write");
  // The strobes launched in the request cycle still follow the core; the next ones are idle.
  property p_immediate;
    clkEn && state_ff == srs_pkg::SRS_RUN && reqQual && !writeBusy
      |=> state_ff == srs_pkg::SRS_SEQ ##1 memCtl_ff == '1;
  endproperty
  a_immediate: assert property (p_immediate) else $error("reset not immediate");
  // Core reset is low in the eight cycles after the request and again in the 129th cycle after it.
  property p_min_len;
    clkEn && state_ff == srs_pkg::SRS_RUN && reqQual
      |=> !coreResetN_ff [*8] ##121 !coreResetN_ff;
  endproperty
  a_min_len: assert property (p_min_len) else $error("reset sequence too short");
  property p_hold_done;
    state_ff == srs_pkg::SRS_HOLD |-> seqCnt_ff == srs_pkg::SEQ_LAST;
  endproperty
  a_hold_done: assert property (p_hold_done) else $error("hold before count ended");
  property p_div8;
    s_reset_entered |-> cpuClkDiv8 && perClkDiv8;
  endproperty
  a_div8: assert property (p_div8) else $error("clocks not divide by eight");
  property p_strobes;
    clkEn && inReset |=> memCtl == '1 && !battRamSelOe;
  endproperty
  a_strobes: assert property (p_strobes) else $error("strobe active in reset");
  property p_power_switch;
    clkEn && (inReset || powerDown) |=> powerSwitchCtrlOut && !battRamSelOe;
  endproperty
  a_power_switch: assert property (p_power_switch) else $error("power switch low");
  property p_cpu_zero;
    s_reset_entered |-> cpuState.stackPtr == srs_pkg::WORD_ZERO
      && cpuState.progCounter == srs_pkg::WORD_ZERO
      && cpuState.internalVectorBase == srs_pkg::BYTE_ZERO
      && cpuState.externalVectorBase == srs_pkg::BYTE_ZERO;
  endproperty
  a_cpu_zero: assert property (p_cpu_zero) else $error("cpu registers not cleared");
  property p_prio;
    s_reset_entered |-> cpuState.priorityStackReg == srs_pkg::PRIO_RST;
  endproperty
  a_prio: assert property (p_prio) else $error("priority register not all ones");
  property p_mem_defaults;
    s_reset_entered |-> memCfg.waitStates == srs_pkg::WAIT_RST
      && memCfg.csSel == srs_pkg::CS_SEL_RST && memCfg.weEn == srs_pkg::WE_EN_RST;
  endproperty
  a_mem_defaults: assert property (p_mem_defaults) else $error("memory defaults wrong");
  property p_release;
    s_release |=> coreResetN && addrOut == '0;
  endproperty
  a_release: assert property (p_release) else $error("release not clean");
  property p_short_pulse;
    clkEn && state_ff == srs_pkg::SRS_RUN && extRstSync_ff |=> state_ff == srs_pkg::SRS_RUN;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse took reset");
endmodule

// *** tb/srs_partner.sv ***
`timescale 1ns/100ps

// Far side of the sequencer: the reset source and a memory that may be mid-write.
module srs_partner (
  input  wire logic sys_clk,
  output logic      extResetN,
  output logic      writeBusy
);
  initial begin
    extResetN = 1'h1;
    writeBusy = 1'h0;
  end

  // Pulls the pin low for cyc fast cycles; fewer than three processor clocks is a glitch.
  task automatic hold_reset(input int cyc);
    @(posedge sys_clk);
    #2;
    extResetN = 1'h0;
    repeat (cyc) @(posedge sys_clk);
    #2;
    extResetN = 1'h1;
  endtask

  // Starts or ends a memory write cycle that the device has to respect.
  task automatic set_write(input logic busy);
    @(posedge sys_clk);
    #2;
    writeBusy = busy;
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/100ps

module tb;
  logic                                         sys_clk;
  logic                                         nrst;
  logic                                         clkEn;
  logic                                         extResetN;
  logic                                         cpuTick;
  logic                                         writeBusy;
  logic                                         powerDown;
  logic [srs_pkg::ADDR_W-1:0]                   coreAddr;
  srs_pkg::srs_corereq_t                        coreReq;
  srs_pkg::srs_cfgwr_t                          cfgWr;
  srs_pkg::srs_portwr_t                         portWr;
  logic                                         coreResetN;
  logic [srs_pkg::ADDR_W-1:0]                   addrOut;
  srs_pkg::srs_memctl_t                         memCtl;
  logic                                         battRamSelOut;
  logic                                         battRamSelOe;
  logic                                         powerSwitchCtrlOut;
  logic                                         cpuClkDiv8;
  logic                                         perClkDiv8;
  srs_pkg::srs_cpu_t                            cpuState;
  srs_pkg::srs_memcfg_t                         memCfg;
  srs_pkg::srs_port_t [srs_pkg::NUM_PORTS-1:0]  portPins;
  int                                           miscompares;
  int                                           cmp_count;
  int                                           cycles;
  int                                           tickDiv;
  int                                           tickCnt;
  logic [15:0]                                  lfsrState;

  srs_reset_sequencer srs_reset_sequencer_i (
    .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .extResetN(extResetN),
    .cpuTick(cpuTick), .writeBusy(writeBusy), .powerDown(powerDown),
    .coreAddr(coreAddr), .coreReq(coreReq), .cfgWr(cfgWr), .portWr(portWr),
    .coreResetN(coreResetN), .addrOut(addrOut), .memCtl(memCtl),
    .battRamSelOut(battRamSelOut), .battRamSelOe(battRamSelOe),
    .powerSwitchCtrlOut(powerSwitchCtrlOut), .cpuClkDiv8(cpuClkDiv8),
    .perClkDiv8(perClkDiv8), .cpuState(cpuState), .memCfg(memCfg), .portPins(portPins)
  );

  srs_partner srs_partner_i (
    .sys_clk(sys_clk), .extResetN(extResetN), .writeBusy(writeBusy)
  );

  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Processor clock as a one-cycle tick every tickDiv fast cycles.
  initial begin
    cpuTick = 1'h0;
    tickCnt = 0;
    forever begin
      @(posedge sys_clk);
      #2;
      tickCnt = tickCnt + 1;
      cpuTick = (tickCnt % tickDiv == 0);
    end
  end

  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end

  function automatic logic [15:0] rnd();
    lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
    return lfsrState;
  endfunction

  function automatic srs_pkg::srs_cpu_t exp_cpu();
    return '{stackPtr: srs_pkg::WORD_ZERO, progCounter: srs_pkg::WORD_ZERO,
             internalVectorBase: srs_pkg::BYTE_ZERO, externalVectorBase: srs_pkg::BYTE_ZERO,
             priorityStackReg: srs_pkg::PRIO_RST};
  endfunction

  function automatic logic [111:0] exp_ports();
    srs_pkg::srs_port_t [srs_pkg::NUM_PORTS-1:0] p;
    p = '0;
    p[srs_pkg::PORT_B].oe = srs_pkg::PB_OE_RST;
    p[srs_pkg::PORT_C].oe = srs_pkg::PC_OE_RST;
    p[srs_pkg::PORT_C].dat = srs_pkg::PC_DAT_RST;
    return p;
  endfunction

  // Default selection: boot chip select and boot output enable only, writes off.
  function automatic srs_pkg::srs_memctl_t exp_strobes(input srs_pkg::srs_corereq_t r);
    srs_pkg::srs_memctl_t m;
    m = '1;
    m.csN0 = !(r.memRd || r.memWr);
    m.oeN0 = !r.memRd;
    m.bufEnN = !(r.memRd || r.memWr || r.ioRd || r.ioWr);
    m.ioRdN = !r.ioRd;
    m.ioWrN = !r.ioWr;
    m.fetchN = !r.fetch;
    return m;
  endfunction

  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic cfg_write(input logic [2:0] sel, input logic [15:0] d);
    step(1);
    cfgWr = '{en: 1'h1, sel: srs_pkg::srs_sel_t'(sel), data: d};
    step(1);
    cfgWr.en = 1'h0;
  endtask

  task automatic port_write(input logic [2:0] idx, input srs_pkg::srs_port_t v);
    step(1);
    portWr = '{en: 1'h1, idx: idx, val: v};
    step(1);
    portWr.en = 1'h0;
  endtask

  task automatic check_defaults();
    check("coreResetN", coreResetN, 1'h0);
    check("memCtl", memCtl, 10'h3FF);
    check("battRamSelOe", battRamSelOe, 1'h0);
    check("powerSwitch", powerSwitchCtrlOut, 1'h1);
    check("div8", {cpuClkDiv8, perClkDiv8}, 2'h3);
    check("cpuState", cpuState, exp_cpu());
    check("memCfg", memCfg, {srs_pkg::WAIT_RST, srs_pkg::CS_SEL_RST,
                             srs_pkg::OE_SEL_RST, srs_pkg::WE_EN_RST});
    check("portPins", portPins, exp_ports());
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (coreResetN !== 1'h1 && n < 400) begin
      step(1);
      n = n + 1;
    end
    check("addrOut", addrOut, 20'h00000);
    step(1);
    check("powerSwitch", powerSwitchCtrlOut, 1'h0);
    check("battRamSelOe", battRamSelOe, 1'h1);
  endtask

  initial begin
    int                         n;
    logic [15:0]                d;
    logic [19:0]                a1;
    logic                       bad;
    srs_pkg::srs_port_t         pv;
    srs_pkg::srs_memctl_t       m;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    tickDiv = 4;
    lfsrState = 16'hC3B2;
    nrst = 1'h0;
    clkEn = 1'h1;
    powerDown = 1'h0;
    coreAddr = 20'h00000;
    coreReq = '0;
    cfgWr = '0;
    portWr = '0;
    repeat (5) @(posedge sys_clk);
    #2;
    nrst = 1'h1;
    step(2);
    check_defaults();
    wait_run(n);
    check("porLength", n + 2 >= srs_pkg::SEQ_MIN_CYC, 1'h1);
    $display("power-on test done");
    for (int s = 0; s < 7; s++) begin
      d = rnd();
      cfg_write(3'(s), d);
      case (s)
        0: check("sp", cpuState.stackPtr, d);
        1: check("pc", cpuState.progCounter, d);
        2: check("ivb", cpuState.internalVectorBase, d[7:0]);
        3: check("evb", cpuState.externalVectorBase, d[7:0]);
        4: check("prio", cpuState.priorityStackReg, d[7:0]);
        5: check("memCfg", memCfg, d[8:0]);
        default: check("div8", {perClkDiv8, cpuClkDiv8}, d[1:0]);
      endcase
    end
    for (int i = 0; i < 7; i++) begin
      d = rnd();
      pv = '{oe: d[15:8], dat: d[7:0]};
      port_write(3'(i), pv);
      check("port", portPins[i], pv);
    end
    cfg_write(srs_pkg::SRS_SEL_CLK, 16'h0000);
    d = rnd();
    a1 = {d[3:0], rnd()};
    coreAddr = a1;
    step(2);
    check("addrOut", addrOut, a1);
    $display("write test done");
    srs_partner_i.hold_reset(24);
    check("memCtl", memCtl, 10'h3FF);
    check_defaults();
    coreAddr = ~a1;
    cfg_write(srs_pkg::SRS_SEL_PRIO, 16'h0000);
    check("prio", cpuState.priorityStackReg, srs_pkg::PRIO_RST);
    port_write(3'h0, '1);
    check("port", portPins[0], 16'h0000);
    check("addrOut", addrOut, a1);
    wait_run(n);
    check("seqLength", n >= 100, 1'h1);
    coreReq.memRd = 1'h1;
    coreReq.fetch = 1'h1;
    step(2);
    check("strobes", memCtl, exp_strobes(coreReq));
    coreReq = '0;
    coreReq.memWr = 1'h1;
    step(2);
    check("writeStrobes", {memCtl.weN0, memCtl.weN1}, 2'h3);
    coreReq = '0;
    $display("pin reset test done");
    srs_partner_i.hold_reset(3);
    bad = 1'h0;
    repeat (40) begin
      step(1);
      bad = bad | (coreResetN !== 1'h1);
    end
    check("glitchIgnored", bad, 1'h0);
    $display("glitch test done");
    coreReq.memRd = 1'h1;
    srs_partner_i.set_write(1'h1);
    srs_partner_i.hold_reset(24);
    check("deferCs", memCtl.csN0, 1'h0);
    srs_partner_i.set_write(1'h0);
    step(3);
    check("memCtl", memCtl, 10'h3FF);
    check_defaults();
    wait_run(n);
    $display("defer test done");
    tickDiv = 16;
    cfg_write(srs_pkg::SRS_SEL_CLK, 16'h0000);
    check("div8", {cpuClkDiv8, perClkDiv8}, 2'h0);
    srs_partner_i.set_write(1'h1);
    srs_partner_i.hold_reset(200);
    check("slowForced", memCtl, 10'h3FF);
    check("div8", {cpuClkDiv8, perClkDiv8}, 2'h3);
    srs_partner_i.set_write(1'h0);
    coreReq = '0;
    wait_run(n);
    tickDiv = 4;
    $display("slow clock test done");
    powerDown = 1'h1;
    step(2);
    check("battRamSelOe", battRamSelOe, 1'h0);
    check("powerSwitch", powerSwitchCtrlOut, 1'h1);
    powerDown = 1'h0;
    step(2);
    check("battRamSelOe", battRamSelOe, 1'h1);
    check("powerSwitch", powerSwitchCtrlOut, 1'h0);
    $display("power-down test done");
    for (int i = 0; i < 32; i++) begin
      coreReq = 5'(rnd());
      powerDown = (rnd() > 16'hC000);
      step(2);
      check("randStrobes", memCtl, exp_strobes(coreReq));
      check("battSel", battRamSelOut, 1'h1);
      check("battOe", battRamSelOe, !powerDown);
      check("powerSwitch", powerSwitchCtrlOut, powerDown);
    end
    powerDown = 1'h0;
    m = memCtl;
    clkEn = 1'h0;
    cfg_write(srs_pkg::SRS_SEL_SP, 16'hFFFF);
    coreReq = 5'(rnd());
    step(3);
    check("frozen", memCtl, m);
    check("frozenSp", cpuState.stackPtr, srs_pkg::WORD_ZERO);
    clkEn = 1'h1;
    cfg_write(srs_pkg::SRS_SEL_MEM, 16'h000F);
    coreReq = '0;
    coreReq.memWr = 1'h1;
    step(2);
    check("battSelLow", battRamSelOut, 1'h0);
    check("writeEnabled", {memCtl.csN0, memCtl.weN0, memCtl.weN1}, 3'h4);
    nrst = 1'h0;
    step(2);
    nrst = 1'h1;
    step(2);
    check_defaults();
    wait_run(n);
    check("rstLength", n + 2 >= srs_pkg::SEQ_MIN_CYC, 1'h1);
    $display("random and mid-run reset test done");
    finish_test();
  end
endmodule
